/* jcp_pkg.sv */
// Constants, encodings and state type of the scan configuration port
package jcp_pkg;
	// Instruction register
	localparam int unsigned IR_W = 4;
	typedef logic [IR_W-1:0] jcp_ir_t;
	localparam jcp_ir_t IR_EXTEST = 4'h0;
	localparam jcp_ir_t IR_PRELOAD = 4'h1;
	localparam jcp_ir_t IR_IDCODE = 4'h2;
	localparam jcp_ir_t IR_GLOBAL = 4'h4;
	localparam jcp_ir_t IR_PIXEL = 4'h8;
	localparam jcp_ir_t IR_BYPASS = 4'hf;
	localparam jcp_ir_t IR_CAPTURE = 4'h1;
	localparam jcp_ir_t IR_RESET = IR_IDCODE;

	// Identification register
	localparam int unsigned ID_W = 32;
	// Value is arbitrary, bit 0 kept high as scan practice expects
	localparam logic [ID_W-1:0] ID_CODE_DEF = 32'h0a5a_c001;

	// Boundary register: 8 groups of output bus plus pedestal bus, 4 extra cells
	localparam int unsigned N_GRP = 8;
	localparam int unsigned DO_W = 8;
	localparam int unsigned DI_W = 2;
	localparam int unsigned GRP_PITCH = DO_W + DI_W;
	localparam int unsigned SPECIAL_W = 4;
	localparam int unsigned HALF_SPLIT = 4;
	localparam int unsigned BSR_LEN = N_GRP * GRP_PITCH + SPECIAL_W;
	localparam int unsigned BSR_SYNC = 43;
	localparam int unsigned BSR_CLK = 42;
	localparam int unsigned BSR_RCLK = 41;
	localparam int unsigned BSR_TIE = 40;

	// Global configuration chain
	localparam int unsigned GL_LEN = 240;
	localparam int unsigned BIAS_N = 25;
	localparam int unsigned BIAS_W = 7;
	localparam int unsigned BIAS_PITCH = 8;
	localparam int unsigned MISC_LSB = 200;
	localparam int unsigned MISC_W = GL_LEN - MISC_LSB;
	localparam int unsigned TIE_BIT = 207;

	localparam int unsigned PIX_LEN_DEF = 64;

	// Index of the top output-bus cell of group k, TDI end is the highest index
	function automatic int unsigned do_msb(input int unsigned k);
		return BSR_LEN - 1 - GRP_PITCH * k - ((k >= HALF_SPLIT) ? SPECIAL_W : 0);
	endfunction

	typedef enum logic [3:0] {
		tap_tlr, tap_rti, tap_sds, tap_cpdr, tap_shdr, tap_e1dr, tap_pdr, tap_e2dr,
		tap_updr, tap_sis, tap_cpir, tap_shir, tap_e1ir, tap_pir, tap_e2ir, tap_upir
	} jcp_tap_e;
endpackage

/* jcp_top.sv */
// Scan test-access and configuration port with boundary, identity and config chains
// Function
// - TAP state advances per TMS each rising edge
// - Async TAP reset spares chain contents
// - Four-bit instruction, shifted least significant first
// - Codes 0000/0001 select boundary chain modes
// - Code 0010 shifts 32-bit identity, LSB first
// - Code 1111 routes TDI through bypass
// - Codes 0100/1000 select global/pixel chains
// - EXTEST captures block outputs, drives pads
// - Preload captures input pads, drives block inputs
// - Fast clock and restart never scan-driven
// - Boundary order groups 0-3, four specials, 4-7
// - Returned clock observed; inject enable from config, from its boundary cell after preload
// - Global chain 240 bits, MSB first
// - Shadow latches load on entering Update-DR
// - Capture never copies latches back
// - Global chain samples TDI on falling edge
// - Rising-edge flop after global chain drives TDO
// - Low chain part: 7-bit code, monitor bit
// - Bias codes unsigned, 127 full scale
`timescale 1ns/1ps
`default_nettype none
module jcp_top #(
	parameter logic [jcp_pkg::ID_W-1:0] ID_CODE = jcp_pkg::ID_CODE_DEF,
	parameter int unsigned PIX_LEN = jcp_pkg::PIX_LEN_DEF
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tck,
	input wire logic tap_async_reset_low,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	input wire logic [jcp_pkg::N_GRP*jcp_pkg::DO_W-1:0] core_adc_output_bus,
	output logic [jcp_pkg::N_GRP*jcp_pkg::DO_W-1:0] pad_adc_output_bus,
	input wire logic [jcp_pkg::N_GRP*jcp_pkg::DI_W-1:0] pad_pedestal_input_bus,
	output logic [jcp_pkg::N_GRP*jcp_pkg::DI_W-1:0] core_pedestal_input_bus,
	input wire logic pad_sync_restart,
	input wire logic pad_fast_clock,
	input wire logic returned_fast_clock,
	output logic test_injection_enable,
	output logic [jcp_pkg::BIAS_N*jcp_pkg::BIAS_W-1:0] bias_code_field,
	output logic [jcp_pkg::BIAS_N-1:0] monitor_connect_bit,
	output logic [jcp_pkg::MISC_W-1:0] misc_config,
	output logic [PIX_LEN-1:0] pixel_config
);
	import jcp_pkg::*;

	wire logic trst_n = tap_async_reset_low;

	// TAP controller
	jcp_tap_e tap_st_r;
	jcp_tap_e tap_nxt;

	always_comb begin
		tap_nxt = tap_st_r;
		case (tap_st_r)
			tap_tlr: tap_nxt = tms ? tap_tlr : tap_rti;
			tap_rti: tap_nxt = tms ? tap_sds : tap_rti;
			tap_sds: tap_nxt = tms ? tap_sis : tap_cpdr;
			tap_cpdr: tap_nxt = tms ? tap_e1dr : tap_shdr;
			tap_shdr: tap_nxt = tms ? tap_e1dr : tap_shdr;
			tap_e1dr: tap_nxt = tms ? tap_updr : tap_pdr;
			tap_pdr: tap_nxt = tms ? tap_e2dr : tap_pdr;
			tap_e2dr: tap_nxt = tms ? tap_updr : tap_shdr;
			tap_updr: tap_nxt = tms ? tap_sds : tap_rti;
			tap_sis: tap_nxt = tms ? tap_tlr : tap_cpir;
			tap_cpir: tap_nxt = tms ? tap_e1ir : tap_shir;
			tap_shir: tap_nxt = tms ? tap_e1ir : tap_shir;
			tap_e1ir: tap_nxt = tms ? tap_upir : tap_pir;
			tap_pir: tap_nxt = tms ? tap_e2ir : tap_pir;
			tap_e2ir: tap_nxt = tms ? tap_upir : tap_shir;
			tap_upir: tap_nxt = tms ? tap_sds : tap_rti;
			default: tap_nxt = tap_tlr;
		endcase
	end

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			tap_st_r <= tap_tlr;
		end else begin
			tap_st_r <= tap_nxt;
		end
	end

	wire logic cap_dr_w = (tap_st_r == tap_cpdr);
	wire logic shift_dr_w = (tap_st_r == tap_shdr);
	wire logic upd_dr_w = (tap_nxt == tap_updr);
	wire logic upd_ir_w = (tap_nxt == tap_upir);

	// Instruction register
	jcp_ir_t ir_sr_r;
	jcp_ir_t ir_r;

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			ir_sr_r <= IR_CAPTURE;
		end else if (tap_st_r == tap_cpir) begin
			ir_sr_r <= IR_CAPTURE;
		end else if (tap_st_r == tap_shir) begin
			ir_sr_r <= {tdi, ir_sr_r[IR_W-1:1]};
		end
	end

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			ir_r <= IR_RESET;
		end else if (upd_ir_w) begin
			ir_r <= ir_sr_r;
		end
	end

	wire logic sel_bsr = (ir_r == IR_EXTEST) || (ir_r == IR_PRELOAD);
	wire logic sel_id = (ir_r == IR_IDCODE);
	wire logic sel_glob = (ir_r == IR_GLOBAL);
	wire logic sel_pix = (ir_r == IR_PIXEL);
	wire logic sel_byp = !(sel_bsr || sel_id || sel_glob || sel_pix);

	// Capture sources come from the system domain and pads, so they are synchronised
	wire logic [BSR_LEN-1:0] cap_w;
	logic [BSR_LEN-1:0] cap1_r;
	logic [BSR_LEN-1:0] cap2_r;
	logic tie_r;

	for (genvar k = 0; k < N_GRP; k++) begin : g_cap
		localparam int unsigned MSB = do_msb(k);
		assign cap_w[MSB -: DO_W] = core_adc_output_bus[k*DO_W +: DO_W];
		assign cap_w[MSB-DO_W -: DI_W] = pad_pedestal_input_bus[k*DI_W +: DI_W];
	end
	assign cap_w[BSR_SYNC] = pad_sync_restart;
	assign cap_w[BSR_CLK] = pad_fast_clock;
	assign cap_w[BSR_RCLK] = returned_fast_clock;
	assign cap_w[BSR_TIE] = tie_r;

	always_ff @(posedge tck) begin
		cap1_r <= cap_w;
		cap2_r <= cap1_r;
	end

	// Data chains carry no reset: TAP reset must leave their contents alone
	logic [BSR_LEN-1:0] bsr_sr_r;
	logic [BSR_LEN-1:0] bsu_r;
	logic [ID_W-1:0] id_sr_r;
	logic byp_r;
	logic [PIX_LEN-1:0] pix_sr_r;
	logic [PIX_LEN-1:0] pix_sh_r;
	logic [GL_LEN-1:0] gsr_r;
	logic [GL_LEN-1:0] gsh_r;

	always_ff @(posedge tck) begin
		if (sel_bsr && cap_dr_w) begin
			bsr_sr_r <= cap2_r;
		end else if (sel_bsr && shift_dr_w) begin
			bsr_sr_r <= {tdi, bsr_sr_r[BSR_LEN-1:1]};
		end
	end

	always_ff @(posedge tck) begin
		if (sel_bsr && upd_dr_w) begin
			bsu_r <= bsr_sr_r;
		end
	end

	always_ff @(posedge tck) begin
		if (sel_id && cap_dr_w) begin
			id_sr_r <= ID_CODE;
		end else if (sel_id && shift_dr_w) begin
			id_sr_r <= {tdi, id_sr_r[ID_W-1:1]};
		end
	end

	always_ff @(posedge tck) begin
		if (sel_byp && cap_dr_w) begin
			byp_r <= 1'b0;
		end else if (sel_byp && shift_dr_w) begin
			byp_r <= tdi;
		end
	end

	always_ff @(posedge tck) begin
		if (sel_pix && shift_dr_w) begin
			pix_sr_r <= {tdi, pix_sr_r[PIX_LEN-1:1]};
		end
	end

	always_ff @(posedge tck) begin
		if (sel_pix && upd_dr_w) begin
			pix_sh_r <= pix_sr_r;
		end
	end

	// Global chain has no capture at all, so a read-back returns what was shifted
	always_ff @(negedge tck) begin
		if (sel_glob && shift_dr_w) begin
			gsr_r <= {gsr_r[GL_LEN-2:0], tdi};
		end
	end

	always_ff @(posedge tck) begin
		if (sel_glob && upd_dr_w) begin
			gsh_r <= gsr_r;
		end
	end

	// Output flop is the rising-edge stage behind the global chain
	wire logic dr_out_w = sel_bsr ? bsr_sr_r[0] :
		sel_id ? id_sr_r[0] :
		sel_glob ? gsr_r[GL_LEN-1] :
		sel_pix ? pix_sr_r[0] : byp_r;
	logic tdo_r;

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			tdo_r <= 1'b0;
		end else begin
			tdo_r <= (tap_st_r == tap_shir) ? ir_sr_r[0] : dr_out_w;
		end
	end
	assign tdo = tdo_r;

	// Update event crosses as a toggle; chains stay stable until the next update
	logic upd_tg_r;
	logic pre_app_r;

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			upd_tg_r <= 1'b0;
		end else if (upd_dr_w || upd_ir_w) begin
			upd_tg_r <= ~upd_tg_r;
		end
	end

	always_ff @(posedge tck or negedge trst_n) begin
		if (!trst_n) begin
			pre_app_r <= 1'b0;
		end else if (upd_ir_w) begin
			pre_app_r <= 1'b0;
		end else if (ir_r == IR_PRELOAD && upd_dr_w) begin
			pre_app_r <= 1'b1;
		end
	end

	// System domain
	logic rs1_r;
	logic rs2_r;
	wire logic sys_rst_n = rs2_r;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rs1_r <= 1'b0;
			rs2_r <= 1'b0;
		end else begin
			rs1_r <= 1'b1;
			rs2_r <= rs1_r;
		end
	end

	logic tg1_r;
	logic tg2_r;
	logic tg3_r;

	always_ff @(posedge clk_sys or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			tg1_r <= 1'b0;
			tg2_r <= 1'b0;
			tg3_r <= 1'b0;
		end else begin
			tg1_r <= upd_tg_r;
			tg2_r <= tg1_r;
			tg3_r <= tg2_r;
		end
	end
	wire logic ld_w = tg2_r ^ tg3_r;

	jcp_ir_t ir_s_r;
	logic pre_s_r;
	logic [BSR_LEN-1:0] bsu_s_r;

	always_ff @(posedge clk_sys or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			ir_s_r <= IR_RESET;
			pre_s_r <= 1'b0;
			bsu_s_r <= '0;
		end else if (ld_w) begin
			ir_s_r <= ir_r;
			pre_s_r <= pre_app_r;
			bsu_s_r <= bsu_r;
		end
	end
	wire logic ext_s_w = (ir_s_r == IR_EXTEST);

	logic [N_GRP*DI_W-1:0] din1_r;
	logic [N_GRP*DI_W-1:0] din2_r;

	always_ff @(posedge clk_sys) begin
		din1_r <= pad_pedestal_input_bus;
		din2_r <= din1_r;
	end

	logic [N_GRP*DO_W-1:0] pad_dout_r;
	logic [N_GRP*DI_W-1:0] core_din_r;

	for (genvar k = 0; k < N_GRP; k++) begin : g_pad
		localparam int unsigned MSB = do_msb(k);
		always_ff @(posedge clk_sys or negedge sys_rst_n) begin
			if (!sys_rst_n) begin
				pad_dout_r[k*DO_W +: DO_W] <= '0;
				core_din_r[k*DI_W +: DI_W] <= '0;
			end else begin
				pad_dout_r[k*DO_W +: DO_W] <= ext_s_w ? bsu_s_r[MSB -: DO_W] :
					core_adc_output_bus[k*DO_W +: DO_W];
				core_din_r[k*DI_W +: DI_W] <= pre_s_r ? bsu_s_r[MSB-DO_W -: DI_W] :
					din2_r[k*DI_W +: DI_W];
			end
		end
	end
	assign pad_adc_output_bus = pad_dout_r;
	assign core_pedestal_input_bus = core_din_r;

	// Configuration outputs, copied from the shadow latches on each update event
	logic [BIAS_N*BIAS_W-1:0] bias_r;
	logic [BIAS_N-1:0] mon_r;
	logic [MISC_W-1:0] misc_r;
	logic [PIX_LEN-1:0] pix_s_r;

	for (genvar g = 0; g < BIAS_N; g++) begin : g_bias
		always_ff @(posedge clk_sys or negedge sys_rst_n) begin
			if (!sys_rst_n) begin
				bias_r[g*BIAS_W +: BIAS_W] <= '0;
				mon_r[g] <= 1'b0;
			end else if (ld_w) begin
				// Plain unsigned code, all ones is full scale
				bias_r[g*BIAS_W +: BIAS_W] <= gsh_r[g*BIAS_PITCH +: BIAS_W];
				mon_r[g] <= gsh_r[g*BIAS_PITCH + BIAS_W];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			misc_r <= '0;
			pix_s_r <= '0;
		end else if (ld_w) begin
			misc_r <= gsh_r[GL_LEN-1:MISC_LSB];
			pix_s_r <= pix_sh_r;
		end
	end

	always_ff @(posedge clk_sys or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			tie_r <= 1'b0;
		end else begin
			tie_r <= pre_s_r ? bsu_s_r[BSR_TIE] : misc_r[TIE_BIT-MISC_LSB];
		end
	end

	assign bias_code_field = bias_r;
	assign monitor_connect_bit = mon_r;
	assign misc_config = misc_r;
	assign pixel_config = pix_s_r;
	assign test_injection_enable = tie_r;

	// Checks
	tap_reset_a: assert property (@(posedge clk_sys) !trst_n |-> tap_st_r == tap_tlr)
		else $error("TAP not held in reset state");
	tap_walk_a: assert property (@(posedge tck) disable iff (!trst_n)
		tms [*5] |=> tap_st_r == tap_tlr)
		else $error("Five TMS highs did not reach reset state");
	shift_hold_a: assert property (@(posedge tck) disable iff (!trst_n)
		(shift_dr_w && !tms) |=> shift_dr_w)
		else $error("Shift-DR left with TMS low");
	shadow_load_a: assert property (@(posedge tck) disable iff (!trst_n)
		(tap_st_r == tap_e1dr && tms && sel_glob) |=> gsh_r == $past(gsr_r))
		else $error("Shadow latches missed update");
	glob_nocap_a: assert property (@(negedge tck) disable iff (!trst_n)
		(cap_dr_w && sel_glob) |-> gsr_r === $past(gsr_r))
		else $error("Global chain altered by capture");
	glob_fall_a: assert property (@(negedge tck) disable iff (!trst_n)
		(shift_dr_w && sel_glob) |=> gsr_r[0] == $past(tdi))
		else $error("Global chain missed falling-edge sample");
	glob_tdo_a: assert property (@(posedge tck) disable iff (!trst_n)
		(sel_glob && tap_st_r != tap_shir) |=> tdo_r === $past(gsr_r[GL_LEN-1]))
		else $error("Output flop not fed by last global cell");
	id_capture_a: assert property (@(posedge tck) disable iff (!trst_n)
		(cap_dr_w && sel_id) |=> id_sr_r == ID_CODE)
		else $error("Identity not captured");
	byp_clear_a: assert property (@(posedge tck) disable iff (!trst_n)
		(cap_dr_w && sel_byp) |=> !byp_r)
		else $error("Bypass not cleared on capture");
	byp_undef_a: assert property (@(posedge tck) disable iff (!trst_n)
		(shift_dr_w && ir_r == 4'h3) |=> byp_r == $past(tdi))
		else $error("Undefined code not routed to bypass");
	extest_drive_a: assert property (@(posedge clk_sys) disable iff (!sys_rst_n)
		ext_s_w |=> pad_dout_r[DO_W-1:0] === $past(bsu_s_r[do_msb(0) -: DO_W]))
		else $error("Pads not driven from boundary update");
endmodule
`default_nettype wire

/* jcp_host.sv */
// Scan host model: makes the test clock only within frames and shifts the chains
`timescale 1ns/1ps
`default_nettype none
module jcp_host (
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n,
	input wire logic tdo
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		// Starts released so the first tap_reset gives the TAP a real falling edge
		trst_n = 1'b1;
	end
	// One 15 ns period; tms and tdi settle well clear of both clock edges
	task automatic tick(input logic m, input logic d);
		tms = m;
		tdi = d;
		#4 tck = 1'b1;
		#7.5 tck = 1'b0;
		#3.5;
	endtask
	task automatic tap_reset();
		trst_n = 1'b0;
		#20 trst_n = 1'b1;
		#10 tick(1'b0, 1'b0);
	endtask
	// From idle: capture, n bits, update, back to idle
	// Global cells sample on the falling edge, so their bits move one tick early
	task automatic scan(input logic ir, input logic glob, input int n,
		input logic [239:0] din, output logic [239:0] dout);
		dout = '0;
		tick(1'b1, tdi);
		if (ir) tick(1'b1, tdi);
		tick(1'b0, tdi);
		for (int t = 0; t <= n; t++) begin
			tick(t == n, glob ? din[(t < n) ? t : 0] : din[(t > 0) ? t - 1 : 0]);
			if (glob && t < n) dout[t] = tdo;
			if (!glob && t > 0) dout[t - 1] = tdo;
		end
		tick(1'b1, ~tdi);
		tick(1'b0, ~tdi);
		// Idle data line toggles so a stale bit is never mistaken for data
		tdi = ~tdi;
	endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the scan configuration port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import jcp_pkg::*;
	localparam int unsigned PL = 8;
	logic clk_sys, rst_n, tck, trst_n, tms, tdi, tdo, restart, fclk, rclk, tie;
	logic [63:0] core_bus, pad_do;
	logic [15:0] ped_pad, ped_core;
	logic [174:0] bias;
	logic [24:0] mon;
	logic [39:0] misc;
	logic [PL-1:0] pix;
	logic [239:0] dout, p1, p2, nb;
	int num_errors = 0;
	int n_checks = 0;
	jcp_ir_t bcodes [4] = '{IR_BYPASS, 4'h3, 4'h6, 4'hc};
	jcp_top #(.PIX_LEN(PL)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .tck(tck),
		.tap_async_reset_low(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo),
		.core_adc_output_bus(core_bus), .pad_adc_output_bus(pad_do),
		.pad_pedestal_input_bus(ped_pad), .core_pedestal_input_bus(ped_core),
		.pad_sync_restart(restart), .pad_fast_clock(fclk), .returned_fast_clock(rclk),
		.test_injection_enable(tie), .bias_code_field(bias), .monitor_connect_bit(mon),
		.misc_config(misc), .pixel_config(pix));
	jcp_host i_host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic end_sim();
		if (num_errors == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask
	// Margin for the two-flop crossing into the system domain
	task automatic settle();
		repeat (10) @(posedge clk_sys);
		#1;
	endtask
	function automatic logic [239:0] rev(input logic [239:0] v, input int n);
		logic [239:0] r;
		r = '0;
		for (int i = 0; i < n; i++) r[i] = v[n - 1 - i];
		return r;
	endfunction
	function automatic int msb(input int k);
		return 83 - 10 * k - ((k >= 4) ? 4 : 0);
	endfunction
	function automatic logic [83:0] cap_vec(input logic t);
		logic [83:0] v;
		v = '0;
		for (int k = 0; k < 8; k++) begin
			v[msb(k)-:8] = core_bus[8*k+:8];
			v[msb(k)-8-:2] = ped_pad[2*k+:2];
		end
		v[43:40] = {restart, fclk, rclk, t};
		return v;
	endfunction
	task automatic load_ir(input jcp_ir_t code);
		i_host.scan(1'b1, 1'b0, 4, {236'h0, code}, dout);
		check(dout[3:0] === IR_CAPTURE, "instruction capture");
		settle();
	endtask
	task automatic chk_gl(input logic [239:0] p);
		for (int g = 0; g < 25; g++)
			check(bias[7*g+:7] === p[8*g+:7] && mon[g] === p[8*g+7], "bias group");
		check(bias[6:0] === p[6:0], "bias code 0");
		check(misc === p[239:200], "misc config");
		check(tie === p[207], "inject enable from config");
	endtask
	initial begin : watchdog
		#500000;
		num_errors++;
		end_sim();
	end
	initial begin : main
		rst_n = 1'b0;
		core_bus = 64'h0123_4567_89ab_cdef;
		ped_pad = 16'h1b6c;
		restart = 1'b1;
		fclk = 1'b0;
		rclk = 1'b1;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		settle();
		i_host.tap_reset();
		i_host.scan(1'b0, 1'b0, 32, '0, dout);
		check(dout[31:0] === ID_CODE_DEF, "id after tap reset");
		load_ir(IR_IDCODE);
		i_host.scan(1'b0, 1'b0, 32, '0, dout);
		check(dout[31:0] === ID_CODE_DEF, "id code");
		for (int i = 0; i < 4; i++) begin
			load_ir(bcodes[i]);
			i_host.scan(1'b0, 1'b0, 8, 240'ha5, dout);
			check(dout[7:0] === 8'h4a, "bypass path");
		end
		for (int g = 0; g < 25; g++) p1[8*g+:8] = 8'(g * 37 + 127);
		p1[239:200] = 40'hc3_5aa5_0ff1;
		p2 = ~p1;
		// Global configuration follows the identity and bypass checks and comes before the boundary modes are exercised
		load_ir(IR_GLOBAL);
		i_host.scan(1'b0, 1'b1, 240, rev(p1, 240), dout);
		settle();
		chk_gl(p1);
		i_host.scan(1'b0, 1'b1, 240, rev(p2, 240), dout);
		check(rev(dout, 240) === p1, "global read back");
		settle();
		chk_gl(p2);
		i_host.tap_reset();
		load_ir(IR_GLOBAL);
		i_host.scan(1'b0, 1'b1, 240, rev(p1, 240), dout);
		check(rev(dout, 240) === p2, "chain kept over tap reset");
		settle();
		chk_gl(p1);
		nb = '0;
		nb[83:0] = 84'h5_3c96_a0f1_e2d4_c3b7_8899;
		repeat (5) i_host.tick(1'b1, 1'b0);
		i_host.tick(1'b0, 1'b0);
		load_ir(IR_EXTEST);
		i_host.scan(1'b0, 1'b0, 84, nb, dout);
		check(dout[83:0] === cap_vec(p1[207]), "extest capture");
		settle();
		for (int k = 0; k < 8; k++)
			check(pad_do[8*k+:8] === nb[msb(k)-:8], "pad drive");
		load_ir(IR_PRELOAD);
		check(pad_do === core_bus, "pads follow block again");
		nb = ~nb;
		i_host.scan(1'b0, 1'b0, 84, nb, dout);
		check(dout[83:0] === cap_vec(p1[207]), "preload capture");
		settle();
		for (int k = 0; k < 8; k++)
			check(ped_core[2*k+:2] === nb[msb(k)-8-:2], "block input drive");
		check(tie === nb[40], "inject enable cell");
		load_ir(IR_PIXEL);
		i_host.scan(1'b0, 1'b0, PL, '1, dout);
		settle();
		check(pix === 8'hff, "pixel chain");
		check(ped_core === ped_pad, "block inputs follow pads again");
		check(tie === p1[207], "inject enable back from config");
		end_sim();
	end
endmodule
`default_nettype wire
